// ===== twi_mt_map.vh
// Register offsets, field positions, status codes and timing counts for the two-wire master.
`ifndef TWI_MT_MAP_VH
`define TWI_MT_MAP_VH
`define ADDR_LINK_CONTROL 2'h0
`define ADDR_BUS_STATE_CODE 2'h1
`define ADDR_SHIFT_BYTE 2'h2
`define CTL_RATE_HIGH 7
`define CTL_LINK_ENABLE 6
`define CTL_BEGIN 5
`define CTL_HALT 4
`define CTL_PENDING 3
`define CTL_ACK_ENABLE 2
`define CTL_RATE_MID 1
`define CTL_RATE_LOW 0
`define LINK_CONTROL_RESET 8'h00
`define SHIFT_BYTE_RESET 8'h00
`define ST_START_SENT 8'h08
`define ST_RESTART_SENT 8'h10
`define ST_ADDR_ACK 8'h18
`define ST_ADDR_NACK 8'h20
`define ST_DATA_ACK 8'h28
`define ST_DATA_NACK 8'h30
`define ST_ARB_LOST 8'h38
`define ST_MR_ADDR_ACK 8'h40
`define ST_MR_ADDR_NACK 8'h48
`define ST_IDLE 8'hf8
`define QUARTER_BASE 16'd25
`define BUS_FREE_CYCLES 16'd400
`endif

// ===== twi_master_transmitter.v
// Two-wire bus controller in master transmitter mode with a plain register port.
// Notes on behaviour
// - Address write bit selects master transmitter; read bit selects master receiver.
// - A start request waits until the bus is free before issuing START.
// - After START the pending flag sets and status reads 08h.
// - After address and acknowledge, pending sets with status 18h, 20h or 38h.
// - Shift byte writes count only while pending; otherwise the old byte is sent.
// - After repeated START status reads 10h and any slave may be addressed.
// - In 08h or 10h with no requests, the address goes out, acknowledge sampled.
// - In 10h an address with read bit goes out, then receiver operation follows.
// - Status 18h, 20h, 28h, 30h for address and data acknowledge outcomes.
// - In 18h to 30h with no requests, the data byte goes out.
// - In 18h to 30h, begin alone issues a repeated START.
// - In 18h to 30h, halt alone sends STOP and clears halt.
// - Both begin and halt send STOP then START, clearing halt.
// - Lost arbitration gives 38h; release bus, or restart when bus frees.
// - While pending, clock is held low and no bus operation starts.
// - Pending never sets after a STOP is finished.
// - Shift byte reads return the last byte written while pending; the bus is never sampled into it.
//
// Decided for this implementation: the register addresses and strobed register access.
`include "twi_mt_map.vh"

module twi_master_transmitter (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire [1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_o,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  output wire master_receiver_o
);

  localparam S_IDLE = 4'd0;
  localparam S_WAIT_FREE = 4'd1;
  localparam S_START = 4'd2;
  localparam S_HOLD = 4'd3;
  localparam S_BIT = 4'd4;
  localparam S_ACK = 4'd5;
  localparam S_RESTART = 4'd6;
  localparam S_STOP = 4'd7;
  localparam S_RECEIVER = 4'd8;

  wire scl_sync_reg, sda_sync_reg;
  reg [15:0] idle_cnt_reg;
  reg [15:0] quarter;
  reg [7:0] read_mux;
  reg scl_prev_reg, sda_prev_reg;
  reg bus_busy_reg;
  reg [7:0] control_reg;
  reg [7:0] status_reg;
  reg [7:0] shift_reg;
  reg [3:0] state_reg;
  reg [1:0] phase_reg;
  reg [15:0] tick_cnt_reg;
  reg [2:0] bit_cnt_reg;
  reg is_addr_reg;
  reg was_restart_reg;
  reg stop_then_start_reg;
  reg scl_low_reg, sda_low_reg;
  reg receiver_reg;

  wire pending = control_reg[`CTL_PENDING];
  wire enable = control_reg[`CTL_LINK_ENABLE];
  wire begin_req = control_reg[`CTL_BEGIN];
  wire halt_req = control_reg[`CTL_HALT];
  wire [2:0] rate = {control_reg[`CTL_RATE_HIGH], control_reg[`CTL_RATE_MID],
    control_reg[`CTL_RATE_LOW]};
  // Quarter bit period grows with the rate field; exact encoding is left open.
  always @* begin
    case (rate)
      3'd0: quarter = `QUARTER_BASE;
      3'd1: quarter = `QUARTER_BASE + 16'd8;
      3'd2: quarter = `QUARTER_BASE + 16'd16;
      3'd3: quarter = `QUARTER_BASE + 16'd24;
      3'd4: quarter = `QUARTER_BASE + 16'd32;
      3'd5: quarter = `QUARTER_BASE + 16'd40;
      3'd6: quarter = `QUARTER_BASE + 16'd48;
      default: quarter = `QUARTER_BASE + 16'd56;
    endcase
  end
  wire tick = (tick_cnt_reg >= quarter);
  wire start_seen = scl_sync_reg & sda_prev_reg & ~sda_sync_reg;
  wire stop_seen = scl_sync_reg & ~sda_prev_reg & sda_sync_reg;

  assign scl_o = 1'b0;
  assign scl_oe_o = scl_low_reg;
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low_reg;
  assign master_receiver_o = receiver_reg;

  // Both bus lines come from outside the clock domain and are synchronised first.
  twi_line_sync i_scl_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .line_i(scl_i),
    .line_o(scl_sync_reg)
  );

  twi_line_sync i_sda_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .line_i(sda_i),
    .line_o(sda_sync_reg)
  );

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      bus_busy_reg <= 1'b0;
      idle_cnt_reg <= 16'h0000;
    end else begin
      scl_prev_reg <= scl_sync_reg;
      sda_prev_reg <= sda_sync_reg;
      // A bus left high long enough counts as free, so a lost STOP never locks out START.
      if (!(scl_sync_reg && sda_sync_reg)) begin
        idle_cnt_reg <= 16'h0000;
      end else if (idle_cnt_reg != `BUS_FREE_CYCLES) begin
        idle_cnt_reg <= idle_cnt_reg + 16'h0001;
      end
      if (start_seen) begin
        bus_busy_reg <= 1'b1;
      end else if (stop_seen || idle_cnt_reg == `BUS_FREE_CYCLES) begin
        bus_busy_reg <= 1'b0;
      end
    end
  end

  always @* begin
    case (reg_addr_i)
      `ADDR_LINK_CONTROL: read_mux = control_reg;
      `ADDR_BUS_STATE_CODE: read_mux = status_reg;
      `ADDR_SHIFT_BYTE: read_mux = shift_reg;
      default: read_mux = 8'h00;
    endcase
  end

  // Read data is zero outside the cycle after a read strobe.
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= read_mux;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      control_reg <= `LINK_CONTROL_RESET;
      status_reg <= `ST_IDLE;
      shift_reg <= `SHIFT_BYTE_RESET;
      state_reg <= S_IDLE;
      phase_reg <= 2'd0;
      tick_cnt_reg <= 16'h0000;
      bit_cnt_reg <= 3'd0;
      is_addr_reg <= 1'b0;
      was_restart_reg <= 1'b0;
      stop_then_start_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      receiver_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      if (reg_wr_i && reg_addr_i == `ADDR_LINK_CONTROL) begin
        // Software may clear the pending flag but never set it.
        control_reg <= {reg_wdata_i[7:4], reg_wdata_i[3] & pending, reg_wdata_i[2:0]};
      end
      if (reg_wr_i && reg_addr_i == `ADDR_SHIFT_BYTE && pending) begin
        shift_reg <= reg_wdata_i;
      end
      case (state_reg)
        S_IDLE: begin
          scl_low_reg <= 1'b0;
          sda_low_reg <= 1'b0;
          if (enable && begin_req && !pending) begin
            state_reg <= S_WAIT_FREE;
          end
        end
        S_WAIT_FREE: begin
          if (!bus_busy_reg && scl_sync_reg && sda_sync_reg && tick) begin
            state_reg <= S_START;
            phase_reg <= 2'd0;
          end
        end
        S_START: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          if (phase_reg == 2'd0) begin
            sda_low_reg <= 1'b1;
          end else if (phase_reg == 2'd2) begin
            scl_low_reg <= 1'b1;
            control_reg[`CTL_PENDING] <= 1'b1;
            control_reg[`CTL_BEGIN] <= 1'b0;
            status_reg <= was_restart_reg ? `ST_RESTART_SENT : `ST_START_SENT;
            is_addr_reg <= 1'b1;
            state_reg <= S_HOLD;
          end
        end
        S_HOLD: begin
          scl_low_reg <= 1'b1;
          phase_reg <= 2'd0;
          bit_cnt_reg <= 3'd7;
          // Acknowledge enable is never consulted here.
          if (!pending) begin
            if (status_reg == `ST_ARB_LOST) begin
              scl_low_reg <= 1'b0;
              sda_low_reg <= 1'b0;
              was_restart_reg <= 1'b0;
              state_reg <= begin_req ? S_WAIT_FREE : S_IDLE;
            end else if (halt_req) begin
              stop_then_start_reg <= begin_req;
              state_reg <= S_STOP;
            end else if (begin_req && !is_addr_reg) begin
              state_reg <= S_RESTART;
            end else begin
              state_reg <= S_BIT;
            end
          end
        end
        S_BIT: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          case (phase_reg)
            2'd0: sda_low_reg <= ~shift_reg[bit_cnt_reg];
            2'd1: scl_low_reg <= 1'b0;
            2'd2: begin
              if (!scl_sync_reg) begin
                phase_reg <= 2'd2;
              end else if (shift_reg[bit_cnt_reg] && !sda_sync_reg) begin
                sda_low_reg <= 1'b0;
                scl_low_reg <= 1'b0;
                status_reg <= `ST_ARB_LOST;
                control_reg[`CTL_PENDING] <= 1'b1;
                state_reg <= S_HOLD;
              end
            end
            default: begin
              scl_low_reg <= 1'b1;
              if (bit_cnt_reg == 3'd0) begin
                state_reg <= S_ACK;
              end else begin
                bit_cnt_reg <= bit_cnt_reg - 3'd1;
              end
            end
          endcase
        end
        S_ACK: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          case (phase_reg)
            2'd0: sda_low_reg <= 1'b0;
            2'd1: scl_low_reg <= 1'b0;
            2'd2: if (!scl_sync_reg) phase_reg <= 2'd2;
            default: begin
              scl_low_reg <= 1'b1;
              if (is_addr_reg && shift_reg[0]) begin
                receiver_reg <= 1'b1;
                status_reg <= sda_sync_reg ? `ST_MR_ADDR_NACK : `ST_MR_ADDR_ACK;
                state_reg <= S_RECEIVER;
              end else begin
                if (is_addr_reg) begin
                  status_reg <= sda_sync_reg ? `ST_ADDR_NACK : `ST_ADDR_ACK;
                end else begin
                  status_reg <= sda_sync_reg ? `ST_DATA_NACK : `ST_DATA_ACK;
                end
                state_reg <= S_HOLD;
              end
              control_reg[`CTL_PENDING] <= 1'b1;
              is_addr_reg <= 1'b0;
            end
          endcase
        end
        S_RESTART: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          if (phase_reg == 2'd0) begin
            sda_low_reg <= 1'b0;
          end else if (phase_reg == 2'd1) begin
            scl_low_reg <= 1'b0;
          end else if (phase_reg == 2'd3) begin
            was_restart_reg <= 1'b1;
            state_reg <= S_START;
            phase_reg <= 2'd0;
          end
        end
        S_STOP: if (tick) begin
          phase_reg <= phase_reg + 2'd1;
          if (phase_reg == 2'd0) begin
            sda_low_reg <= 1'b1;
          end else if (phase_reg == 2'd1) begin
            scl_low_reg <= 1'b0;
          end else if (phase_reg == 2'd2) begin
            sda_low_reg <= 1'b0;
          end else begin
            // No pending flag after a STOP.
            control_reg[`CTL_HALT] <= 1'b0;
            was_restart_reg <= 1'b0;
            state_reg <= stop_then_start_reg ? S_WAIT_FREE : S_IDLE;
          end
        end
        S_RECEIVER: begin
          // Receiver operation lies outside this block; bus is held while pending, then halt sends STOP, otherwise a repeated START.
          scl_low_reg <= 1'b1;
          if (!pending) begin
            receiver_reg <= 1'b0;
            state_reg <= halt_req ? S_STOP : S_RESTART;
            stop_then_start_reg <= begin_req;
            phase_reg <= 2'd0;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // twi_master_transmitter

// Two-stage synchroniser for one bus line; idles high like the pulled-up line.
module twi_line_sync (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire line_i,
  output reg line_o
);

  reg meta_reg;

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= 1'b1;
      line_o <= 1'b1;
    end else begin
      meta_reg <= line_i;
      line_o <= meta_reg;
    end
  end

endmodule // twi_line_sync

// ===== twi_mt_sva.sv
// Assertion checker bound to the two-wire master's ports.
module twi_mt_sva (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic master_receiver_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire ctl = reg_wr_i && reg_addr_i == 2'h0 && reg_wdata_i[6];
  AST_START_SENT: assert property (
    ctl && reg_wdata_i[5:3] == 3'h4 |-> ##[1:1000] $rose(sda_oe_o))
    else $error("start not driven");
  AST_HOLD_LOW: assert property (
    reg_rd_i && reg_addr_i == 2'h0 ##1 reg_rdata_o[3] |-> ##[0:2] scl_oe_o)
    else $error("clock not held");
  AST_STATUS_SET: assert property (
    reg_rd_i && reg_addr_i == 2'h1 |=> reg_rdata_o inside
    {8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48, 8'hf8})
    else $error("bad status");
  AST_STOP_SENT: assert property (
    ctl && reg_wdata_i[5:3] == 3'h2 |-> ##[1:1000] ($rose(sda_i) && scl_i))
    else $error("stop not driven");
  AST_RESUME: assert property (
    ctl && reg_wdata_i[5:3] == 3'h0 |-> ##[1:200] !scl_oe_o)
    else $error("clock not freed");
  AST_UNMAPPED: assert property (
    reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read");
  AST_RDATA_IDLE: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data stale");
  AST_STOP_QUIET: assert property (
    $rose(sda_i) && scl_i && !scl_oe_o |=> !scl_oe_o [*8])
    else $error("clock after stop");
endmodule // twi_mt_sva

// ===== twi_slave_model.sv
// Slave receiver with a rival master that can pull the data line.
module twi_slave_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_i,
  input wire logic jam_i,
  output logic sda_oe_o,
  output logic [7:0] byte_o,
  output int stops_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic ack_oe = 1'b0;
  logic jam_q = 1'b0;
  initial byte_o = 8'h00;
  initial stops_o = 0;
  assign sda_oe_o = ack_oe | (jam_q & jam_i);
  always @(negedge sda_i) if (scl_i) cnt <= 4'h0;
  always @(posedge sda_i) if (scl_i) begin
    cnt <= 4'h0;
    stops_o <= stops_o + 1;
  end
  always @(posedge scl_i) begin
    if (cnt < 4'h8) sh <= {sh[6:0], sda_i};
    if (cnt < 4'h9) cnt <= cnt + 4'h1;
  end
  always @(negedge scl_i) begin
    jam_q <= jam_i;
    ack_oe <= (cnt == 4'h8) & ack_i;
    if (cnt == 4'h8) byte_o <= sh;
    if (cnt == 4'h9) cnt <= 4'h0;
  end
endmodule // twi_slave_model

// ===== tb_top.sv
// Self-checking bench for the two-wire master transmitter.
`include "twi_mt_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic ack = 1'b1, jam = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rx;
  wire [7:0] rdata;
  wire scl_oe, sda_oe, s_oe, mrx, scl_drv, sda_drv;
  wire scl = ~scl_oe;
  wire sda = ~(sda_oe | s_oe);
  int num_errors = 0, comparisons = 0, cyc = 0, stops;
  twi_master_transmitter i_twi_master_transmitter (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdata), .scl_i(scl), .scl_o(scl_drv), .scl_oe_o(scl_oe), .sda_i(sda),
    .sda_o(sda_drv),
    .sda_oe_o(sda_oe), .master_receiver_o(mrx));
  twi_slave_model i_slave (.scl_i(scl), .sda_i(sda), .ack_i(ack), .jam_i(jam),
    .sda_oe_o(s_oe), .byte_o(rx), .stops_o(stops));
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    {addr, wdata, wr_s} <= {a, d, 1'b1};
    @(posedge sys_clk_i);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    {addr, rd_s} <= {a, 1'b1};
    @(posedge sys_clk_i);
    rd_s <= 1'b0;
    @(negedge sys_clk_i) d = rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // Loads a byte, writes control, then tries a late load that must be dropped.
  task automatic step(input logic [7:0] sh, input logic [7:0] c, input logic [7:0] st);
    logic [7:0] d;
    int n;
    wr(2'h2, sh);
    wr(2'h0, c);
    wr(2'h2, ~sh);
    n = 0;
    do begin
      rd(2'h0, d);
      n++;
    end while (d[3] !== 1'b1 && n < 2000);
    chk(d[3], 1'b1);
    rdc(2'h1, st);
  endtask
  task automatic stop_bus;
    int s;
    s = stops;
    wr(2'h0, 8'h50);
    for (int i = 0; i < 1000 && stops == s; i++) @(posedge sys_clk_i);
    repeat (300) @(posedge sys_clk_i);
    chk(stops, s + 1);
    rdc(2'h0, 8'h40);
  endtask
  task automatic t_reset;
    rdc(2'h0, `LINK_CONTROL_RESET);
    rdc(2'h1, `ST_IDLE);
    rdc(2'h2, `SHIFT_BYTE_RESET);
    rdc(2'h3, 8'h00);
    chk({scl_drv, sda_drv, scl_oe, sda_oe}, 4'h0);
  endtask
  task automatic t_transmit;
    step(8'h00, 8'h60, 8'h08);
    step(8'ha0, 8'h40, 8'h18);
    chk(rx, 8'ha0);
    rdc(2'h2, 8'ha0);
    chk(mrx, 1'b0);
    ack = 1'b0;
    step(8'h3c, 8'h44, 8'h30);
    chk(rx, 8'h3c);
    step(8'h00, 8'h60, 8'h10);
    step(8'ha2, 8'h40, 8'h20);
    ack = 1'b1;
    step(8'h5a, 8'hc7, 8'h28);
    chk(rx, 8'h5a);
    stop_bus;
  endtask
  task automatic t_restart;
    int s;
    step(8'h00, 8'h60, 8'h08);
    step(8'ha0, 8'h40, 8'h18);
    s = stops;
    step(8'h00, 8'h70, 8'h08);
    chk(stops, s + 1);
    rdc(2'h0, 8'h48);
    step(8'ha0, 8'h40, 8'h18);
    step(8'h00, 8'h60, 8'h10);
    step(8'ha1, 8'h40, 8'h40);
    chk(mrx, 1'b1);
    stop_bus;
  endtask
  task automatic t_arb;
    step(8'h00, 8'h60, 8'h08);
    jam = 1'b1;
    step(8'ha0, 8'h40, 8'h38);
    jam = 1'b0;
    wr(2'h0, 8'h40);
    repeat (300) @(posedge sys_clk_i);
    chk({scl_oe, sda_oe}, 2'b00);
  endtask
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial forever #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      test_done;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_transmit;
    t_restart;
    t_arb;
    test_done;
  end
endmodule // tb_top
bind twi_master_transmitter twi_mt_sva i_twi_mt_sva (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .master_receiver_o(master_receiver_o));
